// >>> src/sqcc_control.v
// feature control register bank: sync gating, pin and oscillator controls, correction settings
`include "sqcc_defs.vh"
`timescale 1ns/1ps
`default_nettype none

module sqcc_control (
	input  wire        CLK,
	input  wire        RST_N,
	input  wire        REG_WR,
	input  wire        REG_RD,
	input  wire [12:0] REG_ADDR,
	input  wire [7:0]  REG_WDATA,
	output reg  [7:0]  REG_RDATA,
	input  wire        SYNC_IN,
	input  wire        ENCODE_TICK,
	input  wire        OUTPUT_ENABLE_PIN_N,
	output reg         DIVIDER_RESYNC,
	output reg         DIVIDER_SYNCED,
	output reg         DATA_OUTPUT_ENABLE,
	output reg         LOW_RATE_OSC_ON,
	output reg         DATA_PULLDOWN_ON,
	output reg  [2:0]  CORR_APPLY,
	output reg  [2:0]  CORR_FREEZE,
	output reg  [2:0]  CORR_FORCE,
	output reg  [4:0]  GAIN_LOOP_EXPONENT,
	output reg  [4:0]  PHASE_LOOP_EXPONENT,
	output reg  [4:0]  DC_LOOP_EXPONENT,
	output reg  [14:0] STATIC_GAIN,
	output reg  [12:0] STATIC_PHASE,
	output reg  [13:0] STATIC_DC_I,
	output reg  [13:0] STATIC_DC_Q
);

	// ----------------------------------------------------------------
	// register storage
	// ----------------------------------------------------------------
	localparam NREG = 15;

	reg  [7:0]              regs [0:NREG-1];
	reg  [7:0]              next_rdata;
	reg                     sync_meta;
	reg                     sync_sample;
	reg                     sync_prev;
	reg                     oe_meta;
	reg                     oe_sample;
	reg                     enc_meta;
	reg                     enc_sample;
	reg                     enc_prev;
	reg  [`SQCC_CNT_W-1:0]  gap_count;
	reg                     low_rate;
	wire                    sync_edge;
	wire                    enc_edge;
	wire                    sync_gate;
	wire                    one_shot_sync;
	wire [NREG-1:0]         hit;

	function [7:0] reg_mask;
		input integer idx;
		begin
			case (idx)
				0:       reg_mask = `SQCC_MASK_SYNC;
				1:       reg_mask = `SQCC_MASK_USER_TWO;
				2:       reg_mask = `SQCC_MASK_ENA_FREEZE;
				3:       reg_mask = `SQCC_MASK_FORCE;
				4, 5, 6: reg_mask = `SQCC_MASK_EXP;
				8:       reg_mask = `SQCC_MASK_GAIN_HIGH;
				10:      reg_mask = `SQCC_MASK_PHASE_HIGH;
				12, 14:  reg_mask = `SQCC_MASK_DC_HIGH;
				default: reg_mask = 8'hFF;
			endcase
		end
	endfunction

	function [12:0] reg_addr;
		input integer idx;
		begin
			case (idx)
				0:       reg_addr = `SQCC_ADDR_SYNC_CONTROL;
				1:       reg_addr = `SQCC_ADDR_USER_CONTROL_TWO;
				2:       reg_addr = `SQCC_ADDR_CORR_ENA_FREEZE;
				3:       reg_addr = `SQCC_ADDR_CORR_FORCE;
				4:       reg_addr = `SQCC_ADDR_GAIN_LOOP_BW;
				5:       reg_addr = `SQCC_ADDR_PHASE_LOOP_BW;
				6:       reg_addr = `SQCC_ADDR_DC_LOOP_BW;
				7:       reg_addr = `SQCC_ADDR_INIT_GAIN_LOW;
				8:       reg_addr = `SQCC_ADDR_INIT_GAIN_HIGH;
				9:       reg_addr = `SQCC_ADDR_INIT_PHASE_LOW;
				10:      reg_addr = `SQCC_ADDR_INIT_PHASE_HIGH;
				11:      reg_addr = `SQCC_ADDR_INIT_DC_I_LOW;
				12:      reg_addr = `SQCC_ADDR_INIT_DC_I_HIGH;
				13:      reg_addr = `SQCC_ADDR_INIT_DC_Q_LOW;
				default: reg_addr = `SQCC_ADDR_INIT_DC_Q_HIGH;
			endcase
		end
	endfunction

	function [7:0] reg_reset;
		input integer idx;
		begin
			case (idx)
				0:       reg_reset = `SQCC_RST_SYNC;
				1:       reg_reset = `SQCC_RST_USER_TWO;
				4, 5, 6: reg_reset = `SQCC_RST_EXP;
				default: reg_reset = `SQCC_RST_ZERO;
			endcase
		end
	endfunction

	// ----------------------------------------------------------------
	// input synchronisers and edge detect
	// ----------------------------------------------------------------
	always @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			sync_meta   <= 1'b0;
			sync_sample <= 1'b0;
			sync_prev   <= 1'b0;
			oe_meta     <= 1'b1;
			oe_sample   <= 1'b1;
			enc_meta    <= 1'b0;
			enc_sample  <= 1'b0;
			enc_prev    <= 1'b0;
		end else begin
			sync_meta   <= SYNC_IN;
			sync_sample <= sync_meta;
			sync_prev   <= sync_sample;
			oe_meta     <= OUTPUT_ENABLE_PIN_N;
			oe_sample   <= oe_meta;
			enc_meta    <= ENCODE_TICK;
			enc_sample  <= enc_meta;
			enc_prev    <= enc_sample;
		end
	end

	assign sync_edge = sync_sample & ~sync_prev;
	assign enc_edge  = enc_sample & ~enc_prev;

	// ----------------------------------------------------------------
	// sync gating
	// ----------------------------------------------------------------
	assign sync_gate = regs[0][`SQCC_BIT_MASTER_SYNC] & regs[0][`SQCC_BIT_DIV_SYNC];
	assign one_shot_sync = sync_gate & sync_edge & regs[0][`SQCC_BIT_NEXT_SYNC];

	// ----------------------------------------------------------------
	// register write path
	// ----------------------------------------------------------------
	genvar g;
	generate
		for (g = 0; g < NREG; g = g + 1) begin : gen_reg
			assign hit[g] = (REG_ADDR == reg_addr(g));
			always @(posedge CLK or negedge RST_N) begin
				if (!RST_N) begin
					regs[g] <= reg_reset(g);
				end else if (g == 0 && one_shot_sync) begin
					// self-clear of the divider sync bit wins over a write in the same cycle; the other written bits still land
					if (REG_WR && hit[g]) begin
						regs[g] <= REG_WDATA & reg_mask(g) & ~(8'h01 << `SQCC_BIT_DIV_SYNC);
					end else begin
						regs[g] <= regs[g] & ~(8'h01 << `SQCC_BIT_DIV_SYNC);
					end
				end else if (REG_WR && hit[g]) begin
					regs[g] <= REG_WDATA & reg_mask(g);
				end
			end
		end
	endgenerate

	// ----------------------------------------------------------------
	// register read path
	// ----------------------------------------------------------------
	integer k;
	always @* begin
		next_rdata = 8'h00;
		for (k = 0; k < NREG; k = k + 1) begin
			if (hit[k]) begin
				next_rdata = regs[k];
			end
		end
	end

	always @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			REG_RDATA <= 8'h00;
		end else if (REG_RD) begin
			REG_RDATA <= next_rdata;
		end
	end

	// ----------------------------------------------------------------
	// low encode rate detector
	// ----------------------------------------------------------------
	// counts clocks between encode edges; gap longer than threshold means low rate
	always @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			gap_count <= {`SQCC_CNT_W{1'b0}};
			low_rate  <= 1'b0;
		end else if (!regs[1][`SQCC_BIT_OSC_DETECT]) begin
			gap_count <= {`SQCC_CNT_W{1'b0}};
			low_rate  <= 1'b0;
		end else if (enc_edge) begin
			low_rate  <= (gap_count >= `SQCC_LOW_RATE_CYCLES);
			gap_count <= {`SQCC_CNT_W{1'b0}};
		end else if (gap_count < `SQCC_LOW_RATE_CYCLES) begin
			gap_count <= gap_count + 1'b1;
		end else begin
			low_rate  <= 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// registered outputs
	// ----------------------------------------------------------------
	always @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			DIVIDER_RESYNC      <= 1'b0;
			DIVIDER_SYNCED      <= 1'b0;
			DATA_OUTPUT_ENABLE  <= 1'b0;
			LOW_RATE_OSC_ON     <= 1'b0;
			DATA_PULLDOWN_ON    <= 1'b1;
			CORR_APPLY          <= 3'h0;
			CORR_FREEZE         <= 3'h0;
			CORR_FORCE          <= 3'h0;
			GAIN_LOOP_EXPONENT  <= 5'h02;
			PHASE_LOOP_EXPONENT <= 5'h02;
			DC_LOOP_EXPONENT    <= 5'h02;
			STATIC_GAIN         <= 15'h0000;
			STATIC_PHASE        <= 13'h0000;
			STATIC_DC_I         <= 14'h0000;
			STATIC_DC_Q         <= 14'h0000;
		end else begin
			DIVIDER_RESYNC      <= sync_gate & sync_edge;
			DIVIDER_SYNCED      <= one_shot_sync | (DIVIDER_SYNCED & regs[0][`SQCC_BIT_NEXT_SYNC]);
			// pin is active low; ignored when its enable bit is low
			DATA_OUTPUT_ENABLE  <= ~regs[1][`SQCC_BIT_OE_PIN_ENA] | ~oe_sample;
			LOW_RATE_OSC_ON     <= regs[1][`SQCC_BIT_OSC_RUN] | low_rate;
			DATA_PULLDOWN_ON    <= ~regs[1][`SQCC_BIT_PULLDOWN_DIS];
			CORR_APPLY          <= regs[2][2:0];
			CORR_FREEZE         <= regs[2][`SQCC_BIT_FREEZE_LSB +: 3] & regs[2][2:0];
			CORR_FORCE          <= regs[3][2:0];
			GAIN_LOOP_EXPONENT  <= regs[4][`SQCC_EXP_W-1:0];
			PHASE_LOOP_EXPONENT <= regs[5][`SQCC_EXP_W-1:0];
			DC_LOOP_EXPONENT    <= regs[6][`SQCC_EXP_W-1:0];
			STATIC_GAIN         <= {regs[8][6:0], regs[7]};
			STATIC_PHASE        <= {regs[10][4:0], regs[9]};
			STATIC_DC_I         <= {regs[12][5:0], regs[11]};
			STATIC_DC_Q         <= {regs[14][5:0], regs[13]};
		end
	end

endmodule

`default_nettype wire

// >>> src/sqcc_defs.vh
// register offsets, field positions, reset values and timing counts of the feature control bank
`ifndef SQCC_DEFS_VH
`define SQCC_DEFS_VH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define SQCC_ADDR_SYNC_CONTROL     13'h0100
`define SQCC_ADDR_USER_CONTROL_TWO 13'h0101
`define SQCC_ADDR_CORR_ENA_FREEZE  13'h0110
`define SQCC_ADDR_CORR_FORCE       13'h0111
`define SQCC_ADDR_GAIN_LOOP_BW     13'h0112
`define SQCC_ADDR_PHASE_LOOP_BW    13'h0113
`define SQCC_ADDR_DC_LOOP_BW       13'h0114
`define SQCC_ADDR_INIT_GAIN_LOW    13'h0116
`define SQCC_ADDR_INIT_GAIN_HIGH   13'h0117
`define SQCC_ADDR_INIT_PHASE_LOW   13'h0118
`define SQCC_ADDR_INIT_PHASE_HIGH  13'h0119
`define SQCC_ADDR_INIT_DC_I_LOW    13'h011A
`define SQCC_ADDR_INIT_DC_I_HIGH   13'h011B
`define SQCC_ADDR_INIT_DC_Q_LOW    13'h011C
`define SQCC_ADDR_INIT_DC_Q_HIGH   13'h011D

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define SQCC_BIT_MASTER_SYNC   0
`define SQCC_BIT_DIV_SYNC      1
`define SQCC_BIT_NEXT_SYNC     2
`define SQCC_BIT_PULLDOWN_DIS  0
`define SQCC_BIT_OSC_RUN       2
`define SQCC_BIT_OSC_DETECT    3
`define SQCC_BIT_OE_PIN_ENA    7
`define SQCC_BIT_GAIN          0
`define SQCC_BIT_PHASE         1
`define SQCC_BIT_DC            2
`define SQCC_BIT_FREEZE_LSB    3
`define SQCC_EXP_W             5
`define SQCC_GAIN_W            15
`define SQCC_PHASE_W           13
`define SQCC_DC_W              14

// ----------------------------------------------------------------
// masks of implemented bits
// ----------------------------------------------------------------
`define SQCC_MASK_SYNC         8'h07
`define SQCC_MASK_USER_TWO     8'h8D
`define SQCC_MASK_ENA_FREEZE   8'h3F
`define SQCC_MASK_FORCE        8'h07
`define SQCC_MASK_EXP          8'h1F
`define SQCC_MASK_GAIN_HIGH    8'h7F
`define SQCC_MASK_PHASE_HIGH   8'h1F
`define SQCC_MASK_DC_HIGH      8'h3F

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define SQCC_RST_SYNC          8'h01
`define SQCC_RST_USER_TWO      8'h88
`define SQCC_RST_ZERO          8'h00
`define SQCC_RST_EXP           8'h02

// ----------------------------------------------------------------
// timing: clock 200 MHz, detect threshold 5 MSPS
// ----------------------------------------------------------------
`define SQCC_CLK_MHZ           200
`define SQCC_LOW_RATE_MSPS     5
// clock cycles per encode period at the threshold: 200 / 5, sized to the gap counter
`define SQCC_LOW_RATE_CYCLES   7'd40
`define SQCC_CNT_W             7

`endif

// >>> verification/sqcc_control_checker.sv
// port checks for the feature control register bank
`timescale 1ns/1ps
`default_nettype none
module sqcc_control_checker (
	input wire logic        CLK,
	input wire logic        RST_N,
	input wire logic        REG_WR,
	input wire logic        REG_RD,
	input wire logic [12:0] REG_ADDR,
	input wire logic [7:0]  REG_WDATA,
	input wire logic [7:0]  REG_RDATA,
	input wire logic        SYNC_IN,
	input wire logic        DIVIDER_RESYNC,
	input wire logic        DIVIDER_SYNCED,
	input wire logic        DATA_PULLDOWN_ON,
	input wire logic [2:0]  CORR_APPLY,
	input wire logic [2:0]  CORR_FREEZE,
	input wire logic [2:0]  CORR_FORCE,
	input wire logic [4:0]  GAIN_LOOP_EXPONENT,
	input wire logic [14:0] STATIC_GAIN
);
	default clocking @(posedge CLK); endclocking
	default disable iff (!RST_N);
	a_resync_single: assert property (DIVIDER_RESYNC |=> !DIVIDER_RESYNC)
		else $error("resync pulse too long");
	a_resync_cause: assert property (DIVIDER_RESYNC |-> $past(SYNC_IN, 2))
		else $error("resync without sync input");
	a_synced_cause: assert property ($rose(DIVIDER_SYNCED) |-> DIVIDER_RESYNC)
		else $error("synced flag without resync");
	a_freeze_applied: assert property ((CORR_FREEZE & ~CORR_APPLY) == 3'h0)
		else $error("freeze on a disabled correction");
	a_rdata_hold: assert property (!$past(REG_RD) |-> $stable(REG_RDATA))
		else $error("read data changed without read");
	a_unmapped_zero: assert property (REG_RD && REG_ADDR == 13'h0115 |=> REG_RDATA == 8'h00)
		else $error("unmapped read not zero");
	a_gain_exp_write: assert property (REG_WR && REG_ADDR == 13'h0112 |-> ##2
		GAIN_LOOP_EXPONENT == $past(REG_WDATA[4:0], 2)) else $error("gain exponent not updated");
	a_force_write: assert property (REG_WR && REG_ADDR == 13'h0111 |-> ##2
		CORR_FORCE == $past(REG_WDATA[2:0], 2)) else $error("force bits not updated");
	a_pulldown_write: assert property (REG_WR && REG_ADDR == 13'h0101 |-> ##2
		DATA_PULLDOWN_ON != $past(REG_WDATA[0], 2)) else $error("pull-down not updated");
	a_gain_low_byte: assert property (REG_WR && REG_ADDR == 13'h0116 |-> ##2
		STATIC_GAIN[7:0] == $past(REG_WDATA, 2)) else $error("gain low byte misplaced");
endmodule
`default_nettype wire

// >>> verification/sqcc_far_end.sv
// far side: encode tick source and sync pulse source
`timescale 1ns/1ps
`default_nettype none
module sqcc_far_end (
	input  wire logic       CLK,
	input  wire logic [7:0] TICK_HALF,
	input  wire logic       SYNC_REQ,
	output wire logic       SYNC_IN,
	output var  logic       ENCODE_TICK
);
	logic [7:0] tcnt = 8'h00;
	logic [3:0] scnt = 4'h0;
	initial ENCODE_TICK = 1'b0;
	// tick stands still while the half period is zero; sync held 8 cycles
	always @(negedge CLK) begin
		tcnt <= (tcnt >= TICK_HALF) ? 8'h01 : tcnt + 8'h01;
		if (TICK_HALF != 8'h00 && tcnt >= TICK_HALF)
			ENCODE_TICK <= ~ENCODE_TICK;
		if (SYNC_REQ)
			scnt <= 4'h8;
		else if (scnt != 4'h0)
			scnt <= scnt - 4'h1;
	end
	assign SYNC_IN = (scnt != 4'h0);
endmodule
`default_nettype wire

// >>> verification/testbench.sv
// self-checking bench for the feature control register bank
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic        clk = 0, rst_n = 0, wr = 0, rd = 0, pin_n = 1, sreq = 0;
	logic [12:0] addr = 0;
	logic [7:0]  wdat = 0, rdat, thalf = 0;
	logic        resync, synced, oe, osc, pd, sync_in, tick;
	logic [2:0]  app, frz, frc;
	logic [4:0]  eg, ep, ed;
	logic [14:0] sg;
	logic [12:0] sp;
	logic [13:0] di, dq;
	int          n_mismatch = 0, compares = 0, n_res = 0;
	logic [12:0] ad [16] = '{13'h100, 13'h101, 13'h110, 13'h111, 13'h112, 13'h113, 13'h114, 13'h115,
		13'h116, 13'h117, 13'h118, 13'h119, 13'h11A, 13'h11B, 13'h11C, 13'h11D};
	logic [7:0]  rv [16] = '{8'h01, 8'h88, 8'h00, 8'h00, 8'h02, 8'h02, 8'h02, 8'h00,
		8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
	logic [7:0]  mk [16] = '{8'h07, 8'h8D, 8'h3F, 8'h07, 8'h1F, 8'h1F, 8'h1F, 8'h00,
		8'hFF, 8'h7F, 8'hFF, 8'h1F, 8'hFF, 8'h3F, 8'hFF, 8'h3F};
	logic [7:0]  pv [8] = '{8'h34, 8'h12, 8'hAB, 8'h0C, 8'h55, 8'h2A, 8'h0F, 8'h33};
	logic [7:0]  sv [4] = '{8'h01, 8'h02, 8'h03, 8'h07};
	logic [7:0]  sx [4] = '{8'h00, 8'h00, 8'h02, 8'h01};
	initial forever #2.5 clk = ~clk;
	sqcc_control sqcc_control_inst (.CLK(clk), .RST_N(rst_n), .REG_WR(wr), .REG_RD(rd), .REG_ADDR(addr),
		.REG_WDATA(wdat), .REG_RDATA(rdat), .SYNC_IN(sync_in), .ENCODE_TICK(tick), .OUTPUT_ENABLE_PIN_N(pin_n),
		.DIVIDER_RESYNC(resync), .DIVIDER_SYNCED(synced), .DATA_OUTPUT_ENABLE(oe), .LOW_RATE_OSC_ON(osc),
		.DATA_PULLDOWN_ON(pd), .CORR_APPLY(app), .CORR_FREEZE(frz), .CORR_FORCE(frc),
		.GAIN_LOOP_EXPONENT(eg), .PHASE_LOOP_EXPONENT(ep), .DC_LOOP_EXPONENT(ed), .STATIC_GAIN(sg),
		.STATIC_PHASE(sp), .STATIC_DC_I(di), .STATIC_DC_Q(dq));
	sqcc_far_end sqcc_far_end_inst (.CLK(clk), .TICK_HALF(thalf), .SYNC_REQ(sreq), .SYNC_IN(sync_in),
		.ENCODE_TICK(tick));
	always @(posedge clk) if (resync === 1'b1) n_res <= n_res + 1;
	task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		compares++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic wr_reg(input logic [12:0] a, input logic [7:0] d);
		@(negedge clk);
		addr = a;
		wdat = d;
		wr = 1;
		@(negedge clk);
		wr = 0;
		repeat (3) @(negedge clk);
	endtask
	task automatic rd_reg(input logic [12:0] a, input logic [7:0] e);
		@(negedge clk);
		addr = a;
		rd = 1;
		@(negedge clk);
		rd = 0;
		chk("read data", {8'h00, rdat}, {8'h00, e});
	endtask
	task automatic sync_pulse();
		@(negedge clk);
		sreq = 1;
		@(negedge clk);
		sreq = 0;
		repeat (20) @(negedge clk);
	endtask
	task automatic settle(input int n, input logic [7:0] u2);
		wr_reg(13'h101, u2);
		repeat (n) @(negedge clk);
	endtask
	task automatic end_sim();
		$display("compares %0d mismatches %0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	initial begin
		#100000;
		n_mismatch++;
		end_sim();
	end
	initial begin
		int base;
		repeat (20) @(negedge clk);
		rst_n = 1;
		for (int i = 0; i < 16; i++) rd_reg(ad[i], rv[i]);
		chk("gain exponent", eg, 5'h02);
		chk("pull-down", pd, 1'b1);
		chk("apply", app, 3'h0);
		$display("test reset values done");
		for (int i = 0; i < 16; i++) wr_reg(ad[i], 8'hFF);
		for (int i = 0; i < 16; i++) rd_reg(ad[i], mk[i]);
		chk("static gain", sg, 15'h7FFF);
		chk("phase exponent", ep, 5'h1F);
		chk("dc exponent", ed, 5'h1F);
		chk("pull-down", pd, 1'b0);
		chk("force", frc, 3'h7);
		chk("freeze", frz, 3'h7);
		for (int i = 0; i < 8; i++) wr_reg(13'h116 + i[12:0], pv[i]);
		chk("static gain", sg, 15'h1234);
		chk("static phase", sp, 13'h0CAB);
		chk("static dc i", di, 14'h2A55);
		chk("static dc q", dq, 14'h330F);
		wr_reg(13'h110, 8'h0A);
		chk("apply", app, 3'h2);
		chk("freeze", frz, 3'h0);
		wr_reg(13'h110, 8'h16);
		chk("apply", app, 3'h6);
		chk("freeze", frz, 3'h2);
		$display("test correction fields done");
		for (int i = 0; i < 4; i++) begin
			wr_reg(13'h100, sv[i]);
			base = n_res;
			sync_pulse();
			sync_pulse();
			chk("resync count", n_res - base, {8'h00, sx[i]});
		end
		rd_reg(13'h100, 8'h05);
		chk("synced", synced, 1'b1);
		$display("test sync gating done");
		settle(5, 8'h00);
		chk("output enable", oe, 1'b1);
		settle(5, 8'h80);
		chk("output enable", oe, 1'b0);
		pin_n = 0;
		repeat (5) @(negedge clk);
		chk("output enable", oe, 1'b1);
		thalf = 8'd100;
		settle(500, 8'h00);
		chk("oscillator", osc, 1'b0);
		settle(500, 8'h08);
		chk("oscillator", osc, 1'b1);
		thalf = 8'd5;
		repeat (500) @(negedge clk);
		chk("oscillator", osc, 1'b0);
		settle(5, 8'h0C);
		chk("oscillator", osc, 1'b1);
		$display("test pin and oscillator done");
		end_sim();
	end
endmodule
bind sqcc_control sqcc_control_checker sqcc_control_checker_inst (.CLK, .RST_N, .REG_WR, .REG_RD, .REG_ADDR,
	.REG_WDATA, .REG_RDATA, .SYNC_IN, .DIVIDER_RESYNC, .DIVIDER_SYNCED, .DATA_PULLDOWN_ON, .CORR_APPLY,
	.CORR_FREEZE, .CORR_FORCE, .GAIN_LOOP_EXPONENT, .STATIC_GAIN);
`default_nettype wire
